// >>> bcp_defines.svh
// Purpose: Offsets, field positions and reset values of the change-detect port
// Assumes: 8-bit register bus with byte offsets as printed
// Notes:   Definitions only
`ifndef BCP_DEFINES_SVH
`define BCP_DEFINES_SVH

// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define BCP_ADDR_PORT 8'h06
`define BCP_ADDR_OPTION 8'h81
`define BCP_ADDR_DIR 8'h86
`define BCP_ADDR_IRQCTL 8'h0B
`define BCP_ADDR_STAT 8'h90
`define BCP_ADDR_MASK 8'h91

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define BCP_OPT_PULLUP_N_BIT 7
`define BCP_OPT_EDGE_BIT 6
`define BCP_IRQ_CHG_BIT 0
`define BCP_IRQ_EXT_BIT 1
`define BCP_IRQ_W 2
`define BCP_EXT_PIN 0
`define BCP_LVP_PIN 3
`define BCP_CHG_LO 4
`define BCP_CHG_HI 7

// --------------------------------------------------------------------------
// Reset values and counts
// --------------------------------------------------------------------------
`define BCP_RST_DIR 8'hFF
`define BCP_RST_OPTION 8'hFF
`define BCP_RST_LATCH 8'h00
`define BCP_RST_IRQ 2'h0
`define BCP_SETTLE_CYC 3'h5

`endif

// >>> bcp_pkg.sv
// Purpose: Shared types of the change-detect port
// Assumes: Nothing beyond the defines header
// Notes:   Types only; numbers live in bcp_defines.svh
`default_nettype none

package bcp_pkg;

  // ------------------------------------------------------------------------
  // Register bus request
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bcp_bus_req_t;

  // ------------------------------------------------------------------------
  // Peripheral direction override, one bit per pin
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] dir;
  } bcp_ovr_t;

endpackage

`default_nettype wire

// >>> bcp_port.sv
// Purpose: Eight-pin bidirectional port with pull-ups, change detect and edge irq
// Assumes: Single 200 MHz ref_clk; rstn is power-on/brown-out; other_rst is synchronous
// Notes:   Pin inputs are triple-synchronised; registers answer one cycle after a read
//
// What this block does
// - Eight pins, each with its own output latch and direction bit
// - Direction bit one makes the pin an input, driver off
// - Direction bit zero drives the output latch onto the pin
// - Option bit seven cleared turns on weak pull-ups of all input pins
// - Pull-up is always off on a pin used as an output
// - Pull-ups are off after power-on reset
// - Only upper four input pins join change detection; outputs are excluded
// - Each such pin compares with its value caught at last port access
// - Mismatches are ORed to set the change flag, bit zero
// - A set change flag can wake the device from sleep
// - Any read or write of the port refreshes the compared values
// - Mismatch keeps setting the flag; software accesses port before clearing
// - Pin zero is an external irq input, edge chosen by option bit six
// - An enabled peripheral may force a pin direction, overriding the register
// - Direction and option registers reset to all ones on every reset
// - Data latch undefined at power-on, kept through other resets
// - Low-voltage programming mode takes pin three away from general use
`timescale 1ns/100ps
`default_nettype none
`include "bcp_defines.svh"

module bcp_port
  import bcp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic other_rst,
  input wire bcp_bus_req_t bus_req,
  output logic [7:0] bus_rdata_ff,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out_ff,
  output logic [7:0] pin_oe_ff,
  output logic [7:0] pullup_en_ff,
  input wire bcp_ovr_t periph_ovr,
  input wire logic low_voltage_program_mode,
  input wire logic sleep_active,
  output logic wake_ff,
  output logic irq_ff
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic wr_hit(input bcp_bus_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic rd_hit(input bcp_bus_req_t r, input logic [7:0] a);
    return r.rd && (r.addr == a);
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [7:0] sync3_ff;
  logic [7:0] pin_filt_ff;
  logic [7:0] port_pin_data_ff;
  logic [7:0] pin_direction_mask_ff;
  logic [7:0] misc_config_ff;
  logic [`BCP_CHG_HI:`BCP_CHG_LO] cmp_ff;
  logic ext_prev_ff;
  logic [2:0] settle_ff;
  logic [`BCP_IRQ_W-1:0] irq_control_reg_ff;
  logic [`BCP_IRQ_W-1:0] irq_status_ff;
  logic [`BCP_IRQ_W-1:0] irq_mask_ff;

  logic [7:0] nxt_pin_filt;
  logic [7:0] nxt_port_pin_data;
  logic [`BCP_IRQ_W-1:0] nxt_irq_control_reg;
  logic [`BCP_IRQ_W-1:0] nxt_irq_status;
  logic [`BCP_IRQ_W-1:0] nxt_irq_mask;
  logic [7:0] nxt_rdata;

  logic [7:0] dir_eff;
  logic [7:0] lvp_mask;
  logic [7:0] port_view;
  logic settled;
  logic port_access;
  logic mismatch;
  logic ext_evt;
  logic pin_change_flag;
  logic [`BCP_IRQ_W-1:0] evt_set;

  // --------------------------------------------------------------------------
  // Pin input synchroniser and agreement filter
  // --------------------------------------------------------------------------
  // Stage one feeds stage two only; a bit moves once stages two and three agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      sync3_ff <= 8'h00;
      pin_filt_ff <= 8'h00;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_filt_ff <= nxt_pin_filt;
    end
  end

  assign nxt_pin_filt = (sync2_ff & sync3_ff) | (pin_filt_ff & (sync2_ff ^ sync3_ff));

  // Filter output is only trusted after the pipeline has filled
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      settle_ff <= 3'h0;
    end else if (settle_ff != `BCP_SETTLE_CYC) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  assign settled = (settle_ff == `BCP_SETTLE_CYC);

  // --------------------------------------------------------------------------
  // Direction, override and programming-pin masking
  // --------------------------------------------------------------------------
  assign dir_eff = (periph_ovr.en & periph_ovr.dir) | (~periph_ovr.en & pin_direction_mask_ff);
  assign lvp_mask = low_voltage_program_mode ? (8'h01 << `BCP_LVP_PIN) : 8'h00;
  assign port_view = pin_filt_ff & ~lvp_mask;

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  // Direction and option return to all ones on every kind of reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_direction_mask_ff <= `BCP_RST_DIR;
      misc_config_ff <= `BCP_RST_OPTION;
    end else if (other_rst) begin
      pin_direction_mask_ff <= `BCP_RST_DIR;
      misc_config_ff <= `BCP_RST_OPTION;
    end else begin
      if (wr_hit(bus_req, `BCP_ADDR_DIR)) begin
        pin_direction_mask_ff <= bus_req.wdata;
      end
      if (wr_hit(bus_req, `BCP_ADDR_OPTION)) begin
        misc_config_ff <= bus_req.wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output data latch
  // --------------------------------------------------------------------------
  // Kept through other_rst; the power-on value is arbitrary, zero chosen
  // Bus writes are dropped during other_rst so the latch rides through it
  assign nxt_port_pin_data = (wr_hit(bus_req, `BCP_ADDR_PORT) && !other_rst) ? bus_req.wdata :
    port_pin_data_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_pin_data_ff <= `BCP_RST_LATCH;
    end else begin
      port_pin_data_ff <= nxt_port_pin_data;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive and pull-ups
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out_ff <= 8'h00;
      pin_oe_ff <= 8'h00;
      pullup_en_ff <= 8'h00;
    end else begin
      pin_out_ff <= nxt_port_pin_data;
      pin_oe_ff <= ~dir_eff & ~lvp_mask;
      // Pull-up only where the pin listens; a driven pin must not fight it
      pullup_en_ff <= {8{~misc_config_ff[`BCP_OPT_PULLUP_N_BIT]}} & dir_eff & ~lvp_mask;
    end
  end

  // --------------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------------
  assign port_access = wr_hit(bus_req, `BCP_ADDR_PORT) || rd_hit(bus_req, `BCP_ADDR_PORT);

  // Output pins are masked out of the compare
  assign mismatch = settled &&
    (|((port_view[`BCP_CHG_HI:`BCP_CHG_LO] ^ cmp_ff) & dir_eff[`BCP_CHG_HI:`BCP_CHG_LO]));

  // Each port access refreshes the snapshot; polling therefore hides changes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_ff <= 4'h0;
    end else if (port_access || (settle_ff == `BCP_SETTLE_CYC - 3'h1)) begin
      cmp_ff <= port_view[`BCP_CHG_HI:`BCP_CHG_LO];
    end
  end

  // --------------------------------------------------------------------------
  // External edge interrupt on pin zero
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= port_view[`BCP_EXT_PIN];
    end
  end

  // Option bit six high selects the rising edge, low the falling edge
  assign ext_evt = settled && (misc_config_ff[`BCP_OPT_EDGE_BIT] ?
    (port_view[`BCP_EXT_PIN] && !ext_prev_ff) :
    (!port_view[`BCP_EXT_PIN] && ext_prev_ff));

  // --------------------------------------------------------------------------
  // Flags, status and mask
  // --------------------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[`BCP_IRQ_CHG_BIT] = mismatch;
    evt_set[`BCP_IRQ_EXT_BIT] = ext_evt;
  end

  // Set wins over a software clear, so a live mismatch re-asserts the flag
  assign nxt_irq_control_reg = (wr_hit(bus_req, `BCP_ADDR_IRQCTL) ?
    bus_req.wdata[`BCP_IRQ_W-1:0] : irq_control_reg_ff) | evt_set;

  // Read clears; an event in the same cycle survives the clear
  assign nxt_irq_status = (rd_hit(bus_req, `BCP_ADDR_STAT) ? `BCP_RST_IRQ : irq_status_ff) | evt_set;

  assign nxt_irq_mask = wr_hit(bus_req, `BCP_ADDR_MASK) ? bus_req.wdata[`BCP_IRQ_W-1:0] : irq_mask_ff;

  assign pin_change_flag = irq_control_reg_ff[`BCP_IRQ_CHG_BIT];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_control_reg_ff <= `BCP_RST_IRQ;
      irq_status_ff <= `BCP_RST_IRQ;
      irq_mask_ff <= `BCP_RST_IRQ;
    end else if (other_rst) begin
      irq_control_reg_ff <= `BCP_RST_IRQ;
      irq_status_ff <= `BCP_RST_IRQ;
      irq_mask_ff <= `BCP_RST_IRQ;
    end else begin
      irq_control_reg_ff <= nxt_irq_control_reg;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Interrupt and wake track the flops above with no extra lag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else if (other_rst) begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_status & nxt_irq_mask);
      wake_ff <= sleep_active && nxt_irq_control_reg[`BCP_IRQ_CHG_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `BCP_ADDR_PORT: nxt_rdata = port_view;
        `BCP_ADDR_OPTION: nxt_rdata = misc_config_ff;
        `BCP_ADDR_DIR: nxt_rdata = pin_direction_mask_ff;
        `BCP_ADDR_IRQCTL: nxt_rdata = {6'h00, irq_control_reg_ff};
        `BCP_ADDR_STAT: nxt_rdata = {6'h00, irq_status_ff};
        `BCP_ADDR_MASK: nxt_rdata = {6'h00, irq_mask_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata_ff <= 8'h00;
    end else begin
      bus_rdata_ff <= nxt_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking bcp_cb @(posedge ref_clk);
  endclocking

  default disable iff (!rstn);

  a_input_no_drive: assert property (
    1'b1 |=> ((pin_oe_ff & $past(dir_eff)) == 8'h00))
    else $error("pin driven while configured as input");

  a_output_drives_latch: assert property (
    wr_hit(bus_req, `BCP_ADDR_PORT) && !other_rst |=> (pin_out_ff == $past(bus_req.wdata)))
    else $error("pin output does not follow written latch");

  a_pullup_all_on: assert property (
    !misc_config_ff[`BCP_OPT_PULLUP_N_BIT] && (dir_eff == 8'hFF) && !low_voltage_program_mode
    |=> (pullup_en_ff == 8'hFF))
    else $error("pull-ups not enabled by cleared control bit");

  a_pullup_off_out: assert property (
    (pullup_en_ff & pin_oe_ff) == 8'h00)
    else $error("pull-up left on at a driven pin");

  a_out_excluded: assert property (
    settled && (dir_eff[`BCP_CHG_HI:`BCP_CHG_LO] == 4'h0) && !pin_change_flag
    && !bus_req.wr && !other_rst |=> !pin_change_flag)
    else $error("change flag set by output pins");

  // One edge only: once the mismatch is gone a software clear may win
  a_mismatch_sets: assert property (
    settled && (((port_view[`BCP_CHG_HI:`BCP_CHG_LO] ^ cmp_ff) & dir_eff[`BCP_CHG_HI:`BCP_CHG_LO]) != 4'h0)
    && !other_rst |=> pin_change_flag)
    else $error("mismatch did not set change flag");

  a_access_refresh: assert property (
    port_access |=> (cmp_ff == $past(port_view[`BCP_CHG_HI:`BCP_CHG_LO])))
    else $error("port access did not refresh snapshot");

  a_change_wakes: assert property (
    sleep_active && mismatch && !other_rst |=> wake_ff)
    else $error("change flag did not wake from sleep");

  a_ext_rise: assert property (
    ext_evt && !other_rst |=> irq_control_reg_ff[`BCP_IRQ_EXT_BIT] && irq_status_ff[`BCP_IRQ_EXT_BIT])
    else $error("external edge not flagged");

  a_ext_edge_sel: assert property (
    settled && !misc_config_ff[`BCP_OPT_EDGE_BIT] && port_view[`BCP_EXT_PIN] && !ext_prev_ff |-> !ext_evt)
    else $error("rising edge taken while falling edge selected");

  a_override_dir: assert property (
    (periph_ovr.en == 8'hFF) && !low_voltage_program_mode |=> (pin_oe_ff == ~$past(periph_ovr.dir)))
    else $error("peripheral override ignored");

  a_soft_rst_regs: assert property (
    other_rst |=> (pin_direction_mask_ff == 8'hFF) && (misc_config_ff == 8'hFF)
    ##1 (pullup_en_ff == 8'h00))
    else $error("direction or option not reset");

  a_latch_kept: assert property (
    other_rst |=> $stable(port_pin_data_ff))
    else $error("data latch lost through reset");

  a_lvp_pin_free: assert property (
    low_voltage_program_mode |=> !pin_oe_ff[`BCP_LVP_PIN] && !pullup_en_ff[`BCP_LVP_PIN])
    else $error("programming pin used as general pin");

  a_irq_level: assert property (
    ##1 (irq_ff == |(irq_status_ff & irq_mask_ff)))
    else $error("interrupt output disagrees with status");

endmodule // bcp_port

`default_nettype wire

// >>> bcp_pad_model.sv
// Purpose: Pads and outside drivers of the eight port pins
// Assumes: Device drive wins; otherwise outside driver, then weak pull-up
// Notes:   An undriven pad toggles each cycle instead of holding a level
`timescale 1ns/100ps
`default_nettype none

module bcp_pad_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad
);
  // --------------------------------------------------------------------
  // Pad level
  // --------------------------------------------------------------------
  logic [7:0] float_ff;

  // Floating pad must not look like a stable level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      float_ff <= 8'h55;
    end else begin
      float_ff <= ~float_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pad[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pullup_en[i]) begin
        pad[i] = 1'b1;
      end else begin
        pad[i] = float_ff[i];
      end
    end
  end
endmodule // bcp_pad_model

`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench of the change-detect port
// Assumes: Register model kept in ints, compared at every result
// Notes:   Direction is always written whole, never read-modify-write
`timescale 1ns/100ps
`default_nettype none
`include "bcp_defines.svh"

`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end

module tb_top
  import bcp_pkg::*;
;
  // --------------------------------------------------------------------
  // Bench
  // --------------------------------------------------------------------
  logic ref_clk, rstn, other_rst, low_voltage_program_mode, sleep_active;
  logic wake_ff, irq_ff;
  bcp_bus_req_t bus_req;
  bcp_ovr_t periph_ovr;
  logic [7:0] bus_rdata_ff, pin_in, pin_out_ff, pin_oe_ff, pullup_en_ff;
  logic [7:0] ext_val, ext_en, rv;
  logic [7:0] ra [6];
  logic [7:0] re [6];
  int failures, check_count, seed, m_dir, m_opt, m_lat;

  bcp_port u_bcp_port (.ref_clk(ref_clk), .rstn(rstn), .other_rst(other_rst),
    .bus_req(bus_req), .bus_rdata_ff(bus_rdata_ff), .pin_in(pin_in),
    .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff), .pullup_en_ff(pullup_en_ff),
    .periph_ovr(periph_ovr), .low_voltage_program_mode(low_voltage_program_mode),
    .sleep_active(sleep_active), .wake_ff(wake_ff), .irq_ff(irq_ff));

  bcp_pad_model u_bcp_pad_model (.ref_clk(ref_clk), .rstn(rstn), .pin_out(pin_out_ff),
    .pin_oe(pin_oe_ff), .pullup_en(pullup_en_ff), .ext_val(ext_val), .ext_en(ext_en),
    .pad(pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] eff_dir();
    return (8'(m_dir) & ~periph_ovr.en) | (periph_ovr.dir & periph_ovr.en);
  endfunction
  function automatic logic [7:0] gp_mask();
    return low_voltage_program_mode ? 8'hF7 : 8'hFF;
  endfunction
  function automatic logic [7:0] exp_oe();
    return ~eff_dir() & gp_mask();
  endfunction
  function automatic logic [7:0] exp_pu();
    return m_opt[7] ? 8'h00 : eff_dir() & gp_mask();
  endfunction
  function automatic logic [7:0] exp_port();
    logic [7:0] oe;
    oe = exp_oe();
    return ((oe & 8'(m_lat)) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & exp_pu())) & gp_mask();
  endfunction

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    case (a)
      `BCP_ADDR_PORT: m_lat = d;
      `BCP_ADDR_OPTION: m_opt = d;
      `BCP_ADDR_DIR: m_dir = d;
      default: ;
    endcase
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    v = bus_rdata_ff;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 9; i++) begin
      if (irq_ff === 1'b1) begin
        return;
      end
      @(posedge ref_clk);
      #1;
    end
    failures++;
    end_of_test();
  endtask

  task automatic chk_pins();
    wait_cyc(6);
    `CHK(pin_out_ff, 8'(m_lat))
    `CHK(pin_oe_ff, exp_oe())
    `CHK(pullup_en_ff, exp_pu())
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end

  initial begin
    seed = 73327;
    failures = 0;
    check_count = 0;
    m_dir = 255;
    m_opt = 255;
    m_lat = 0;
    rstn = 1'b0;
    other_rst = 1'b0;
    bus_req = '0;
    periph_ovr = '0;
    low_voltage_program_mode = 1'b0;
    sleep_active = 1'b0;
    ext_val = 8'h00;
    ext_en = 8'hFF;
    ra = '{`BCP_ADDR_OPTION, `BCP_ADDR_DIR, `BCP_ADDR_IRQCTL, `BCP_ADDR_STAT, `BCP_ADDR_MASK, 8'h55};
    re = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    chk_pins();
    `CHK(pullup_en_ff, 8'h00)
    for (int i = 0; i < 6; i++) begin
      rd_reg(ra[i], rv);
      `CHK(rv, re[i])
    end
    // Random direction, latch, overrides and programming mode
    for (int i = 0; i < 12; i++) begin
      periph_ovr <= 16'($random(seed));
      low_voltage_program_mode <= 1'($random(seed));
      ext_val <= 8'($random(seed));
      wr_reg(`BCP_ADDR_PORT, 8'($random(seed)));
      wr_reg(`BCP_ADDR_DIR, 8'($random(seed)));
      wr_reg(`BCP_ADDR_OPTION, {1'($random(seed)), 7'h7F});
      chk_pins();
      rd_reg(`BCP_ADDR_PORT, rv);
      `CHK(rv, exp_port())
    end
    // Peripherals force every pin to input under enabled pull-ups
    low_voltage_program_mode <= 1'b0;
    periph_ovr <= 16'hFFFF;
    wr_reg(`BCP_ADDR_OPTION, 8'h7F);
    chk_pins();
    // Pull-up holds released input pins high
    periph_ovr <= '0;
    low_voltage_program_mode <= 1'b0;
    ext_en <= 8'hF0;
    wr_reg(`BCP_ADDR_DIR, 8'hF3);
    wr_reg(`BCP_ADDR_OPTION, 8'h7F);
    chk_pins();
    rd_reg(`BCP_ADDR_PORT, rv);
    `CHK(rv, exp_port())
    ext_en <= 8'hFF;
    ext_val <= 8'h00;
    sleep_active <= 1'b1;
    wr_reg(`BCP_ADDR_OPTION, 8'hFF);
    wr_reg(`BCP_ADDR_DIR, 8'hBF);
    wr_reg(`BCP_ADDR_PORT, 8'h00);
    wr_reg(`BCP_ADDR_MASK, 8'h01);
    wait_cyc(6);
    rd_reg(`BCP_ADDR_PORT, rv);
    wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
    rd_reg(`BCP_ADDR_STAT, rv);
    // Low pins and an output pin never flag a change
    ext_val <= 8'h0E;
    wait_cyc(6);
    `CHK(irq_ff, 1'b0)
    wr_reg(`BCP_ADDR_PORT, 8'h40);
    wait_cyc(8);
    `CHK(irq_ff, 1'b0)
    ext_val <= 8'h2E;
    wait_irq();
    `CHK(wake_ff, 1'b1)
    rd_reg(`BCP_ADDR_IRQCTL, rv);
    `CHK(rv, 8'h01)
    wr_reg(`BCP_ADDR_MASK, 8'h00);
    wait_cyc(2);
    `CHK(irq_ff, 1'b0)
    // Clear without a port access does not stick
    wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
    rd_reg(`BCP_ADDR_IRQCTL, rv);
    `CHK(rv, 8'h01)
    rd_reg(`BCP_ADDR_PORT, rv);
    wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
    rd_reg(`BCP_ADDR_IRQCTL, rv);
    `CHK(rv, 8'h00)
    rd_reg(`BCP_ADDR_STAT, rv);
    `CHK(rv, 8'h01)
    rd_reg(`BCP_ADDR_STAT, rv);
    `CHK(rv, 8'h00)
    wr_reg(`BCP_ADDR_MASK, 8'h01);
    ext_val <= 8'h0E;
    wait_irq();
    wr_reg(`BCP_ADDR_PORT, 8'h40);
    wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
    rd_reg(`BCP_ADDR_IRQCTL, rv);
    `CHK(rv, 8'h00)
    sleep_active <= 1'b0;
    // Both edge selections of the external interrupt pin
    for (int e = 0; e < 2; e++) begin
      wr_reg(`BCP_ADDR_OPTION, {1'b1, e[0], 6'h3F});
      ext_val[0] <= ~e[0];
      wait_cyc(6);
      wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
      ext_val[0] <= e[0];
      wait_cyc(6);
      rd_reg(`BCP_ADDR_IRQCTL, rv);
      `CHK(rv & 8'h02, 8'h02)
      wr_reg(`BCP_ADDR_IRQCTL, 8'h00);
      ext_val[0] <= ~e[0];
      wait_cyc(6);
      rd_reg(`BCP_ADDR_IRQCTL, rv);
      `CHK(rv & 8'h02, 8'h00)
    end
    // Other reset keeps the latch, restores direction and option
    wr_reg(`BCP_ADDR_PORT, 8'h3C);
    wr_reg(`BCP_ADDR_DIR, 8'h00);
    wr_reg(`BCP_ADDR_OPTION, 8'h00);
    other_rst <= 1'b1;
    @(posedge ref_clk);
    other_rst <= 1'b0;
    m_dir = 255;
    m_opt = 255;
    chk_pins();
    rd_reg(`BCP_ADDR_DIR, rv);
    `CHK(rv, 8'hFF)
    rd_reg(`BCP_ADDR_OPTION, rv);
    `CHK(rv, 8'hFF)
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
